/* dv/fmp_cmd_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ************
// port checker
// ************
module fmp_cmd_chk (
  input wire logic        mclk_in,
  input wire logic        srst_in,
  input wire logic        chip_select_n_in,
  input wire logic        hw_reset_n_in,
  input wire logic        mem_rd_out,
  input wire logic        mem_valid_in,
  input wire logic [31:0] mem_addr_out,
  input wire logic        addr4_out,
  input wire logic        quad_out,
  input wire logic        dpd_out,
  input wire logic        busy_out,
  input wire logic [3:0]  serial_data_lines_oe_out,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic        avs_waitrequest_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  a_rd_in_check: assert property (hw_reset_n_in && $past(hw_reset_n_in, 4) && mem_rd_out |-> busy_out)
    else $error("fetch outside check");
  a_rd_hold: assert property (hw_reset_n_in && $past(hw_reset_n_in, 4) && mem_rd_out && !mem_valid_in
    |=> mem_rd_out && $stable(mem_addr_out)) else $error("fetch dropped");
  a_start_fetch: assert property ($rose(busy_out) |-> mem_rd_out && chip_select_n_in)
    else $error("check start");
  a_reset_modes: assert property ($fell(srst_in) |-> !addr4_out && !quad_out && !dpd_out && !busy_out)
    else $error("reset modes");
  a_dpd_quiet: assert property (dpd_out |-> !busy_out && !mem_rd_out)
    else $error("active in power-down");
  a_dpd_exit_cs: assert property ($fell(dpd_out) |-> chip_select_n_in)
    else $error("exit with cs low");
  a_oe_mode: assert property (|serial_data_lines_oe_out |-> serial_data_lines_oe_out == (quad_out ? 4'hF : 4'h2))
    else $error("oe mode");
  a_avs_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("no answer");
  a_avs_one_wait: assert property (!avs_waitrequest_out |=> avs_waitrequest_out) else $error("wait low twice");
endmodule : fmp_cmd_chk
bind fmp_cmd_top fmp_cmd_chk fmp_cmd_chk_i (.*);
`default_nettype wire

/* dv/fmp_cmd_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fmp_consts.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
// ************
// bench
// ************
module fmp_cmd_top_test;
  logic        mclk_in, srst_in, hw_n, wbusy, mem_v, rd, wr, cs_n, sclk, m_rd, a4, qd, dpd, busy, wt;
  logic [3:0]  hdq, dout, doe, dq_w;
  logic [4:0]  adr;
  logic [7:0]  m_d;
  logic [31:0] m_a, wd, rdata, r, s;
  logic [63:0] c;
  int          miscompares, samples_checked, cyc, n;
  assign dq_w = (doe & dout) | (~doe & hdq);
  fmp_cmd_top fmp_cmd_top_i (.mclk_in(mclk_in), .srst_in(srst_in), .chip_select_n_in(cs_n), .serial_clock_in(sclk),
    .serial_data_lines_in(dq_w), .serial_data_lines_out(dout), .serial_data_lines_oe_out(doe), .hw_reset_n_in(hw_n),
    .write_busy_in(wbusy), .mem_rd_out(m_rd), .mem_addr_out(m_a), .mem_data_in(m_d), .mem_valid_in(mem_v),
    .addr4_out(a4), .quad_out(qd), .dpd_out(dpd), .busy_out(busy), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'h1), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wt));
  fmp_spi_host fmp_spi_host_i (.mclk_in(mclk_in), .quad_in(qd), .dq_in(dq_w), .cs_n_out(cs_n), .sclk_out(sclk),
    .dq_out(hdq));
  initial begin
    mclk_in = 1'h0;
    forever #5 mclk_in = ~mclk_in;
  end
  function automatic logic [7:0] mbyte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hC3;
  endfunction : mbyte
  function automatic logic [63:0] crc_of(input logic [31:0] st, input int len);
    logic [63:0] v;
    logic [7:0]  d;
    v = 64'h0;
    for (int a = 0; a < len; a++) begin
      d = mbyte(st + 32'(a));
      for (int i = 0; i < 8; i++) v = {v[62:0], 1'h0} ^ ((v[63] ^ d[i]) ? `FMP_CRC_POLY : 64'h0);
    end
    return v;
  endfunction : crc_of
  // array memory answers after a random delay
  always @(posedge mclk_in) begin
    mem_v <= 1'h0;
    if (m_rd && !mem_v && $urandom_range(2) == 0) begin
      mem_v <= 1'h1;
      m_d   <= mbyte(m_a);
    end
  end
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    adr <= a;
    wd  <= d;
    rd  <= !w;
    wr  <= w;
    @(posedge mclk_in);
    while (wt !== 1'h0) @(posedge mclk_in);
    r = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask : av
  task automatic cmd(input logic [7:0] code, input int extra);
    fmp_spi_host_i.tx[0] = code;
    fmp_spi_host_i.xfer(1, extra, 0);
  endtask : cmd
  task automatic crc(input logic [31:0] st, input logic [31:0] en, input logic [63:0] x, input int mode);
    logic [151:0] f;
    f = {en, st, x, 24'hFE279B};
    for (int i = 0; i < 19; i++) fmp_spi_host_i.tx[i] = f[8*i+:8];
    fmp_spi_host_i.xfer(19, 0, 0);
    if (mode == 2) return;
    if (mode == 1) begin
      `CHK("busy", 1'h1, busy)
      cmd(`FMP_CMD_SUSPEND, 0);
      av(0, `FMP_REG_FLAG, 0);
      `CHK("susp set", 1'h1, r[2])
    end
    while (busy !== 1'h0) @(posedge mclk_in);
  endtask : crc
  task automatic step(input int k);
    repeat (k) @(posedge mclk_in);
  endtask : step
  task automatic stop_test;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  initial begin
    void'($urandom(29));
    {srst_in, hw_n, wbusy, rd, wr, adr, wd} = {2'h3, 40'h0};
    step(5);
    srst_in <= 1'h0;
    step(3);
    av(0, `FMP_REG_STATUS, 0);
    `CHK("status", 32'h0, r)
    av(0, 5'h14, 0);
    `CHK("unmapped", 32'h0, r)
    cmd(`FMP_CMD_ENTER_4B, 0);
    `CHK("addr4 on", 1'h1, a4)
    cmd(`FMP_CMD_EXIT_4B, 0);
    `CHK("addr4 off", 1'h0, a4)
    cmd(`FMP_CMD_QUAD_ON, 0);
    `CHK("quad on", 1'h1, qd)
    cmd(`FMP_CMD_QUAD_OFF, 0);
    `CHK("quad off", 1'h0, qd)
    $display("modes done");
    wbusy <= 1'h1;
    cmd(`FMP_CMD_DPD, 0);
    wbusy <= 1'h0;
    step(400);
    `CHK("dpd write busy", 1'h0, dpd)
    cmd(`FMP_CMD_DPD, 1);
    step(400);
    `CHK("dpd extra", 1'h0, dpd)
    cmd(`FMP_CMD_DPD, 0);
    step(280);
    `CHK("dpd early", 1'h0, dpd)
    step(40);
    `CHK("dpd in", 1'h1, dpd)
    cmd(`FMP_CMD_ENTER_4B, 0);
    `CHK("addr4 in dpd", 1'h0, a4)
    cmd(`FMP_CMD_RELEASE, 2);
    step(3100);
    `CHK("void release", 1'h1, dpd)
    cmd(`FMP_CMD_RELEASE, 0);
    step(2980);
    `CHK("release early", 1'h1, dpd)
    step(40);
    `CHK("released", 1'h0, dpd)
    cmd(`FMP_CMD_DPD, 0);
    step(320);
    cmd(`FMP_CMD_RST_EN, 0);
    cmd(`FMP_CMD_RST, 0);
    step(4100);
    `CHK("sw reset exit", 1'h0, dpd)
    $display("power done");
    for (int t = 0; t < 4; t++) begin
      s = $urandom_range(32'h03FFFF00);
      n = $urandom_range(55, 24);
      c = crc_of(s, n);
      crc(s, s + 32'(n - 1), t[0] ? c ^ {$urandom, $urandom | 32'h1} : c, t[0]);
      av(0, `FMP_REG_FLAG, 0);
      `CHK("fail flag", t[0], r[4])
      `CHK("susp clear", 1'h0, r[2])
      av(0, `FMP_REG_CRC_LO, 0);
      `CHK("rb lo", t[0] ? c[31:0] : 32'h0, r)
      av(0, `FMP_REG_CRC_HI, 0);
      `CHK("rb hi", t[0] ? c[63:32] : 32'h0, r)
      fmp_spi_host_i.tx[0] = `FMP_CMD_READBACK;
      fmp_spi_host_i.xfer(1, 0, 9);
      for (int b = 0; b < 9; b++) `CHK("spi rb", (t[0] && b < 8) ? c[8*b+:8] : 8'h0, fmp_spi_host_i.rx[b])
      av(1, `FMP_REG_FLAG, 32'h12);
    end
    for (int k = 0; k < 2; k++) begin
      crc(k ? 32'h03FFFFF0 : 32'h100, k ? 32'h04000010 : 32'hFF, 64'h0, 0);
      av(0, `FMP_REG_FLAG, 0);
      `CHK("abort flag", 1'h1, r[1])
      av(1, `FMP_REG_FLAG, 32'h12);
    end
    $display("crc done");
    cmd(`FMP_CMD_ENTER_4B, 0);
    crc(32'h40, 32'h7F, 64'h1, 2);
    hw_n <= 1'h0;
    step(5);
    hw_n <= 1'h1;
    step(10);
    `CHK("abort busy", 1'h0, busy)
    `CHK("addr4 reset", 1'h0, a4)
    step(4100);
    av(0, `FMP_REG_CRC_LO, 0);
    `CHK("rb reset", 32'h0, r)
    $display("reset done");
    stop_test();
  end
endmodule : fmp_cmd_top_test
`default_nettype wire

/* dv/fmp_spi_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ************
// host spi controller model
// ************
module fmp_spi_host (
  input  wire logic       mclk_in,
  input  wire logic       quad_in,
  input  wire logic [3:0] dq_in,
  output logic            cs_n_out,
  output logic            sclk_out,
  output logic      [3:0] dq_out
);
  logic [7:0] tx [0:18];
  logic [7:0] rx [0:8];
  initial {cs_n_out, sclk_out, dq_out} = 6'h20;
  task automatic ph;
    repeat (5) @(posedge mclk_in);
  endtask : ph
  task automatic tick;
    ph();
    sclk_out <= 1'h1;
    ph();
    sclk_out <= 1'h0;
  endtask : tick
  // cs rises right after the last bit or the extra clocks
  task automatic xfer(input int n, input int extra, input int nrd);
    @(posedge mclk_in);
    cs_n_out <= 1'h0;
    for (int i = 0; i < n; i++)
      for (int k = (quad_in ? 1 : 7); k >= 0; k--) begin
        dq_out <= quad_in ? tx[i][k*4+:4] : {~dq_out[3:1], tx[i][k]};
        tick();
      end
    for (int j = 0; j < nrd * 8; j++) begin
      ph();
      sclk_out <= 1'h1;
      rx[j/8][7-j%8] = dq_in[1];
      ph();
      sclk_out <= 1'h0;
    end
    repeat (extra) tick();
    ph();
    cs_n_out <= 1'h1;
    dq_out   <= ~dq_out;
    repeat (8) @(posedge mclk_in);
  endtask : xfer
endmodule : fmp_spi_host
`default_nettype wire

/* logic/fmp_cmd_top.sv */
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fmp_consts.svh"
// ************
// Contract
// - B7h/E9h switch four/three-byte addressing immediately.
// - reset and exit give three-byte addressing.
// - B9h at exact eighth bit, delayed entry.
// - power-down refused while write busy.
// - power-down ignores all but release/reset.
// - extra clocks after ABh void release.
// - release completes after delay, chip select high.
// - resets also leave power-down after recovery.
// - 35h/F5h switch quad protocol immediately.
// - CRC-64 ECMA, zero seed, lsb first.
// - latch ignored; end below start aborts.
// - byte granular range within one die.
// - mismatch sets flag bit four.
// - suspend sets bit two, cleared at end.
// - any reset aborts running check.
// - failed result kept, read via 96h.
// - readback cleared at start and reset.
// - readback from first byte, zeros beyond.
// - chip select rise starts the check.
// ************
module fmp_cmd_top (
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  input  wire logic        chip_select_n_in,
  input  wire logic        serial_clock_in,
  input  wire logic [3:0]  serial_data_lines_in,
  output logic      [3:0]  serial_data_lines_out,
  output logic      [3:0]  serial_data_lines_oe_out,
  input  wire logic        hw_reset_n_in,
  input  wire logic        write_busy_in,
  output logic             mem_rd_out,
  output logic      [31:0] mem_addr_out,
  input  wire logic [7:0]  mem_data_in,
  input  wire logic        mem_valid_in,
  output logic             addr4_out,
  output logic             quad_out,
  output logic             dpd_out,
  output logic             busy_out,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out
);
  fmp_pkg::fmp_state_t       state;
  logic [`FMP_TMR_W-1:0]     timer;
  logic                      hrst_m;
  logic                      hrst_s;
  logic [4:0]                nbytes;
  logic [7:0]                cmd_q;
  logic                      cmd_ok;
  logic                      hdr_ok;
  logic                      rst_en;
  logic [127:0]              seq;
  logic [63:0]               readback;
  logic                      fl_abort;
  logic                      fl_susp;
  logic                      fl_fail;
  logic                      spi_en;
  logic                      crc_run;
  logic [63:0]               crc_val;

  // ************
  // serial front end
  // ************
  fmp_spi_if sp ();

  fmp_spi_rx u_rx (
    .mclk_in     (mclk_in),
    .srst_in     (srst_in),
    .cs_n_in     (chip_select_n_in),
    .sclk_in     (serial_clock_in),
    .dq_in       (serial_data_lines_in),
    .quad_in     (quad_out),
    .sp          (sp.rx),
    .data_out    (serial_data_lines_out),
    .data_oe_out (serial_data_lines_oe_out)
  );

  // ************
  // hardware reset pin synchroniser
  // ************
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      hrst_m <= 1'b1;
      hrst_s <= 1'b1;
    end else begin
      hrst_m <= hw_reset_n_in;
      hrst_s <= hrst_m;
    end
  end

  // ************
  // state decode
  // ************
  wire st_idle  = state == fmp_pkg::st_standby;
  wire st_pd    = state == fmp_pkg::st_dpd;
  wire st_crc   = (state == fmp_pkg::st_fetch) || (state == fmp_pkg::st_shift);
  wire st_end   = state == fmp_pkg::st_done;
  wire tmr_last = timer == `FMP_TMR_W'(1);

  // ************
  // command decode
  // ************
  wire [7:0] rx_byte = sp.byte_data;
  wire first_stb  = sp.byte_stb && (nbytes == 5'h00);
  wire is_rst_cmd = (rx_byte == `FMP_CMD_RST_EN) || (rx_byte == `FMP_CMD_RST);
  wire pd_cmd     = (rx_byte == `FMP_CMD_RELEASE) || is_rst_cmd;
  wire run_cmd    = (rx_byte == `FMP_CMD_SUSPEND) || is_rst_cmd;
  wire accept     = spi_en && (st_idle || (st_pd && pd_cmd) || (st_crc && run_cmd));
  wire take       = first_stb && accept;
  wire exact1     = (nbytes == 5'h01) && !sp.partial;
  wire fin        = sp.cs_rise && cmd_ok;

  wire go_dpd  = fin && exact1 && (cmd_q == `FMP_CMD_DPD) && st_idle && !write_busy_in;
  wire go_rel  = fin && exact1 && (cmd_q == `FMP_CMD_RELEASE) && st_pd;
  wire sw_rst  = fin && exact1 && (cmd_q == `FMP_CMD_RST) && rst_en;
  wire hw_rst  = !hrst_s;
  wire any_rst = hw_rst || sw_rst;

  // ************
  // crc sequence decode
  // ************
  wire        seq_byte = sp.byte_stb && cmd_ok && (cmd_q == `FMP_CMD_CRC) && (nbytes != 5'h00);
  wire [63:0] exp_crc  = seq[63:0];
  wire [31:0] start_a  = seq[95:64];
  wire [31:0] end_a    = seq[127:96];
  wire seq_full  = fin && st_idle && (cmd_q == `FMP_CMD_CRC) && hdr_ok &&
                   (nbytes == `FMP_CRC_SEQ_BYTES) && !sp.partial;
  wire range_bad = (end_a < start_a) || (end_a[`FMP_DIE_BIT] != start_a[`FMP_DIE_BIT]);
  wire crc_go    = seq_full && !range_bad;
  wire crc_abort = seq_full && range_bad;
  wire crc_mis   = crc_val != exp_crc;
  wire susp_req  = take && (rx_byte == `FMP_CMD_SUSPEND) && st_crc;
  wire crc_load  = (state == fmp_pkg::st_fetch) && mem_valid_in;

  fmp_crc64 u_crc (
    .mclk_in  (mclk_in),
    .srst_in  (srst_in),
    .clear_in (crc_go),
    .load_in  (crc_load),
    .byte_in  (mem_data_in),
    .busy_out (crc_run),
    .crc_out  (crc_val)
  );

  // ************
  // frame tracking
  // ************
  always_ff @(posedge mclk_in) begin
    if (srst_in || sp.cs_rise) begin
      nbytes <= 5'h00;
      hdr_ok <= 1'b0;
      cmd_ok <= (srst_in) ? 1'b0 : cmd_ok;
      cmd_q  <= (srst_in) ? 8'h00 : cmd_q;
    end else if (sp.byte_stb) begin
      if (nbytes != 5'h1F) nbytes <= nbytes + 5'h01;
      if (first_stb) begin
        cmd_q  <= rx_byte;
        cmd_ok <= accept;
      end
      if (nbytes == 5'h01) hdr_ok <= rx_byte == `FMP_CMD_CRC_SUB;
      if (nbytes == 5'h02) hdr_ok <= hdr_ok && (rx_byte == `FMP_CMD_CRC_RANGE);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      seq <= 128'h0;
    end else if (seq_byte && (nbytes >= 5'h03) && (nbytes < `FMP_CRC_SEQ_BYTES)) begin
      seq <= {rx_byte, seq[127:8]};
    end
  end

  // ************
  // mode bits
  // ************
  always_ff @(posedge mclk_in) begin
    if (srst_in || any_rst) begin
      addr4_out <= 1'b0;
      quad_out  <= 1'b0;
      rst_en    <= 1'b0;
    end else begin
      if (take && (rx_byte == `FMP_CMD_ENTER_4B)) addr4_out <= 1'b1;
      if (take && (rx_byte == `FMP_CMD_EXIT_4B)) addr4_out <= 1'b0;
      if (take && (rx_byte == `FMP_CMD_QUAD_ON)) quad_out <= 1'b1;
      if (take && (rx_byte == `FMP_CMD_QUAD_OFF)) quad_out <= 1'b0;
      if (fin) rst_en <= exact1 && (cmd_q == `FMP_CMD_RST_EN);
    end
  end

  // ************
  // readback register
  // ************
  always_ff @(posedge mclk_in) begin
    if (srst_in || !sp.cs_active) begin
      sp.tx_en <= 1'b0;
    end else if (take && (rx_byte == `FMP_CMD_READBACK)) begin
      sp.tx_en <= 1'b1;
    end
  end

  wire [7:0] rb_sel = readback[{sp.tx_idx[2:0], 3'b000} +: 8];
  assign sp.tx_data = sp.tx_idx[3] ? 8'h00 : rb_sel;

  always_ff @(posedge mclk_in) begin
    if (srst_in || any_rst || crc_go) begin
      readback <= 64'h0;
    end else if (st_end && crc_mis) begin
      readback <= crc_val;
    end
  end

  // ************
  // flag status, set wins over clear
  // ************
  wire wr_go     = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  wire flag_wr   = wr_go && (avs_address_in == `FMP_REG_FLAG);
  wire ctrl_wr   = wr_go && (avs_address_in == `FMP_REG_CTRL);
  wire clr_abort = flag_wr && avs_writedata_in[`FMP_FL_ABORT_BIT];
  wire clr_fail  = flag_wr && avs_writedata_in[`FMP_FL_FAIL_BIT];

  always_ff @(posedge mclk_in) begin
    if (srst_in || any_rst) begin
      fl_abort <= 1'b0;
      fl_fail  <= 1'b0;
      fl_susp  <= 1'b0;
    end else begin
      fl_abort <= crc_abort || (fl_abort && !clr_abort);
      fl_fail  <= (st_end && crc_mis) || (fl_fail && !clr_fail);
      fl_susp  <= susp_req || (fl_susp && !st_end);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      spi_en <= `FMP_CTRL_RESET;
    end else if (ctrl_wr) begin
      spi_en <= avs_writedata_in[`FMP_CTRL_EN_BIT];
    end
  end

  // ************
  // main sequencer
  // ************
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state        <= fmp_pkg::st_standby;
      timer        <= `FMP_TMR_W'(0);
      dpd_out      <= 1'b0;
      busy_out     <= 1'b0;
      mem_rd_out   <= 1'b0;
      mem_addr_out <= 32'h0;
    end else if (any_rst) begin
      state      <= fmp_pkg::st_recover;
      timer      <= `FMP_TMR_W'(`FMP_RST_CYC);
      busy_out   <= 1'b0;
      mem_rd_out <= 1'b0;
    end else begin
      case (state)
        fmp_pkg::st_standby: begin
          if (go_dpd) begin
            state <= fmp_pkg::st_dpd_in;
            timer <= `FMP_TMR_W'(`FMP_DP_CYC);
          end else if (crc_go) begin
            state        <= fmp_pkg::st_fetch;
            mem_addr_out <= start_a;
            mem_rd_out   <= 1'b1;
            busy_out     <= 1'b1;
          end
        end
        fmp_pkg::st_dpd_in: begin
          timer <= timer - `FMP_TMR_W'(1);
          if (tmr_last) begin
            state   <= fmp_pkg::st_dpd;
            dpd_out <= 1'b1;
          end
        end
        fmp_pkg::st_dpd: begin
          if (go_rel) begin
            state <= fmp_pkg::st_dpd_out;
            timer <= `FMP_TMR_W'(`FMP_RDP_CYC);
          end
        end
        fmp_pkg::st_dpd_out: begin
          timer <= timer - `FMP_TMR_W'(1);
          if (tmr_last) begin
            state   <= fmp_pkg::st_standby;
            dpd_out <= 1'b0;
          end
        end
        fmp_pkg::st_recover: begin
          timer <= timer - `FMP_TMR_W'(1);
          if (tmr_last) begin
            state   <= fmp_pkg::st_standby;
            dpd_out <= 1'b0;
          end
        end
        fmp_pkg::st_fetch: begin
          if (mem_valid_in) begin
            mem_rd_out <= 1'b0;
            state      <= fmp_pkg::st_shift;
          end
        end
        fmp_pkg::st_shift: begin
          if (!crc_run) begin
            if (mem_addr_out == end_a) begin
              state <= fmp_pkg::st_done;
            end else begin
              mem_addr_out <= mem_addr_out + 32'h1;
              mem_rd_out   <= 1'b1;
              state        <= fmp_pkg::st_fetch;
            end
          end
        end
        fmp_pkg::st_done: begin
          busy_out <= 1'b0;
          state    <= fmp_pkg::st_standby;
        end
        default: begin
          state <= fmp_pkg::st_standby;
        end
      endcase
    end
  end

  // ************
  // avalon slave, one wait cycle
  // ************
  wire [31:0] status_word = (32'(busy_out) << `FMP_ST_BUSY_BIT) |
                            (32'(addr4_out) << `FMP_ST_ADDR4_BIT) |
                            (32'(quad_out) << `FMP_ST_QUAD_BIT) |
                            (32'(dpd_out) << `FMP_ST_DPD_BIT);
  wire [31:0] flag_word   = (32'(!busy_out) << `FMP_FL_READY_BIT) |
                            (32'(fl_fail) << `FMP_FL_FAIL_BIT) |
                            (32'(fl_susp) << `FMP_FL_SUSP_BIT) |
                            (32'(fl_abort) << `FMP_FL_ABORT_BIT);
  wire [31:0] rd_word =
    (avs_address_in == `FMP_REG_STATUS) ? status_word :
    (avs_address_in == `FMP_REG_FLAG)   ? flag_word :
    (avs_address_in == `FMP_REG_CRC_LO) ? readback[31:0] :
    (avs_address_in == `FMP_REG_CRC_HI) ? readback[63:32] :
    (avs_address_in == `FMP_REG_CTRL)   ? (32'(spi_en) << `FMP_CTRL_EN_BIT) :
    32'h0;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0;
    end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
      avs_waitrequest_out <= 1'b0;
      if (avs_read_in) avs_readdata_out <= rd_word;
    end else begin
      avs_waitrequest_out <= 1'b1;
    end
  end

endmodule : fmp_cmd_top
`default_nettype wire

/* logic/fmp_consts.svh */
`ifndef FMP_CONSTS_SVH
`define FMP_CONSTS_SVH
// ************
// command codes
// ************
`define FMP_CMD_ENTER_4B     8'hB7
`define FMP_CMD_EXIT_4B      8'hE9
`define FMP_CMD_DPD          8'hB9
`define FMP_CMD_RELEASE      8'hAB
`define FMP_CMD_QUAD_ON      8'h35
`define FMP_CMD_QUAD_OFF     8'hF5
`define FMP_CMD_CRC          8'h9B
`define FMP_CMD_CRC_SUB      8'h27
`define FMP_CMD_CRC_RANGE    8'hFE
`define FMP_CMD_READBACK     8'h96
`define FMP_CMD_RST_EN       8'h66
`define FMP_CMD_RST          8'h99
`define FMP_CMD_SUSPEND      8'h75
`define FMP_CRC_SEQ_BYTES    5'h13
`define FMP_CRC_POLY         64'h42F0E1EBA9EA3693
`define FMP_DIE_BIT          26
// ************
// timing
// ************
`define FMP_CLK_PERIOD_NS    10
`define FMP_T_DP_NS          3000
`define FMP_T_RDP_NS         30000
`define FMP_T_RST_NS         40000
`define FMP_TMR_W            13
`define FMP_DP_CYC  ((`FMP_T_DP_NS + `FMP_CLK_PERIOD_NS - 1) / `FMP_CLK_PERIOD_NS)
`define FMP_RDP_CYC ((`FMP_T_RDP_NS + `FMP_CLK_PERIOD_NS - 1) / `FMP_CLK_PERIOD_NS)
`define FMP_RST_CYC ((`FMP_T_RST_NS + `FMP_CLK_PERIOD_NS - 1) / `FMP_CLK_PERIOD_NS)
// ************
// register map
// ************
`define FMP_REG_STATUS       5'h00
`define FMP_REG_FLAG         5'h04
`define FMP_REG_CRC_LO       5'h08
`define FMP_REG_CRC_HI       5'h0C
`define FMP_REG_CTRL         5'h10
`define FMP_ST_BUSY_BIT      0
`define FMP_ST_ADDR4_BIT     1
`define FMP_ST_QUAD_BIT      2
`define FMP_ST_DPD_BIT       3
`define FMP_FL_ABORT_BIT     1
`define FMP_FL_SUSP_BIT      2
`define FMP_FL_FAIL_BIT      4
`define FMP_FL_READY_BIT     7
`define FMP_CTRL_EN_BIT      0
`define FMP_CTRL_RESET       1'h1
`endif

/* logic/fmp_crc64.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fmp_consts.svh"
module fmp_crc64 (
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  input  wire logic        clear_in,
  input  wire logic        load_in,
  input  wire logic [7:0]  byte_in,
  output wire logic        busy_out,
  output logic      [63:0] crc_out
);
  logic [7:0]  sh;
  logic [3:0]  cnt;
  logic        fb;
  logic [63:0] next_crc;
  // ************
  // one bit per cycle, lsb first
  // ************
  assign fb       = crc_out[63] ^ sh[0];
  assign next_crc = {crc_out[62:0], 1'b0} ^ ({64{fb}} & `FMP_CRC_POLY);
  assign busy_out = cnt != 4'h0;
  always_ff @(posedge mclk_in) begin
    if (srst_in || clear_in) begin
      crc_out <= 64'h0;
      cnt     <= 4'h0;
      sh      <= 8'h00;
    end else if (load_in) begin
      sh  <= byte_in;
      cnt <= 4'h8;
    end else if (busy_out) begin
      crc_out <= next_crc;
      sh      <= {1'b0, sh[7:1]};
      cnt     <= cnt - 4'h1;
    end
  end
endmodule : fmp_crc64
`default_nettype wire

/* logic/fmp_pkg.sv */
`default_nettype none
package fmp_pkg;
  typedef enum logic [2:0] {
    st_standby = 3'b000,
    st_dpd_in  = 3'b001,
    st_dpd     = 3'b010,
    st_dpd_out = 3'b011,
    st_recover = 3'b100,
    st_fetch   = 3'b101,
    st_shift   = 3'b110,
    st_done    = 3'b111
  } fmp_state_t;
endpackage : fmp_pkg
`default_nettype wire

/* logic/fmp_spi_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface fmp_spi_if;
  logic       cs_active;
  logic       cs_rise;
  logic       byte_stb;
  logic [7:0] byte_data;
  logic       partial;
  logic [3:0] tx_idx;
  logic       tx_en;
  logic [7:0] tx_data;
  modport rx  (output cs_active, cs_rise, byte_stb, byte_data, partial, tx_idx,
               input tx_en, tx_data);
  modport top (input cs_active, cs_rise, byte_stb, byte_data, partial, tx_idx,
               output tx_en, tx_data);
endinterface : fmp_spi_if
`default_nettype wire

/* logic/fmp_spi_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module fmp_spi_rx (
  input  wire logic       mclk_in,
  input  wire logic       srst_in,
  input  wire logic       cs_n_in,
  input  wire logic       sclk_in,
  input  wire logic [3:0] dq_in,
  input  wire logic       quad_in,
  fmp_spi_if.rx           sp,
  output logic      [3:0] data_out,
  output logic      [3:0] data_oe_out
);
  logic       cs_m, cs_s, cs_q;
  logic       ck_m, ck_s, ck_q;
  logic [3:0] dq_m, dq_s;
  logic [7:0] sh;
  logic [2:0] bcnt;
  logic [2:0] tcnt;
  logic       rise, fall;
  // ************
  // pin synchronisers and edges
  // ************
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_q <= 1'b1;
      ck_m <= 1'b0;
      ck_s <= 1'b0;
      ck_q <= 1'b0;
      dq_m <= 4'h0;
      dq_s <= 4'h0;
    end else begin
      cs_m <= cs_n_in;
      cs_s <= cs_m;
      cs_q <= cs_s;
      ck_m <= sclk_in;
      ck_s <= ck_m;
      ck_q <= ck_s;
      dq_m <= dq_in;
      dq_s <= dq_m;
    end
  end
  assign rise         = ck_s & ~ck_q & ~cs_s;
  assign fall         = ~ck_s & ck_q & ~cs_s;
  assign sp.cs_active = ~cs_s;
  assign sp.partial   = bcnt != 3'h0;
  // ************
  // byte assembly
  // ************
  always_ff @(posedge mclk_in) begin
    if (srst_in || (cs_s && cs_q)) begin
      bcnt        <= 3'h0;
      sh          <= 8'h00;
      sp.byte_stb <= 1'b0;
      sp.cs_rise  <= 1'b0;
      if (srst_in) sp.byte_data <= 8'h00;
    end else if (cs_s) begin
      sp.byte_stb <= 1'b0;
      sp.cs_rise  <= 1'b1;
    end else begin
      sp.byte_stb <= 1'b0;
      sp.cs_rise  <= 1'b0;
      if (rise && quad_in) begin
        sh   <= {sh[3:0], dq_s};
        bcnt <= bcnt + 3'h4;
        if (bcnt == 3'h4) begin
          sp.byte_stb  <= 1'b1;
          sp.byte_data <= {sh[3:0], dq_s};
        end
      end else if (rise) begin
        sh   <= {sh[6:0], dq_s[0]};
        bcnt <= bcnt + 3'h1;
        if (bcnt == 3'h7) begin
          sp.byte_stb  <= 1'b1;
          sp.byte_data <= {sh[6:0], dq_s[0]};
        end
      end
    end
  end
  // ************
  // readback shifter, falling edges
  // ************
  always_ff @(posedge mclk_in) begin
    if (srst_in || cs_s || !sp.tx_en) begin
      tcnt        <= 3'h0;
      sp.tx_idx   <= 4'h0;
      data_oe_out <= 4'h0;
      data_out    <= 4'h0;
    end else if (fall) begin
      if (quad_in) begin
        data_out    <= (tcnt == 3'h0) ? sp.tx_data[7:4] : sp.tx_data[3:0];
        data_oe_out <= 4'hF;
        tcnt        <= tcnt + 3'h4;
      end else begin
        data_out    <= {2'h0, sp.tx_data[3'h7 - tcnt], 1'b0};
        data_oe_out <= 4'h2;
        tcnt        <= tcnt + 3'h1;
      end
      if (((tcnt == 3'h4) && quad_in) || (tcnt == 3'h7)) begin
        if (sp.tx_idx != 4'hF) sp.tx_idx <= sp.tx_idx + 4'h1;
      end
    end
  end
endmodule : fmp_spi_rx
`default_nettype wire
